// File: logic/vfm_ctrl.sv
// Frame store controller: video buffers, host access, memory cycle
// Notes on behaviour
// - 256x256 byte store, 16-bit byte address
// - Word access uses 15-bit address, both bytes
// - Chip address sent as row then column
// - Address decodes card, block, part, chip
// - Video covers 192x240; rest left to host
// - One video sample every four master clocks
// - Input half of eight bytes stored per cycle
// - Output half loaded eight bytes per cycle
// - Video leaves memory mostly free for host
// - Video waits for running host cycle
// - Every row refreshed once per 64 lines, about 2.9 ms
// - Repeated line refreshes by video readout
// - Line is 910 master clocks long
// - Cycle starts on any request when idle
// - Lock clears quickly; row strobes spaced apart
// - Separate address and data host devices
// - Hold request asserted during host access
// - Select one of seven camera inputs
// - Data write clears read flag; address sets
// - Hold request stays while waiting memory
// - Sequence ends in read-direction state
`timescale 1ns/1ps
`default_nettype none
`include "vfm_defs.svh"
module vfm_ctrl #(
   parameter int LINE_CLKS = 910,
   parameter int SAMPLE_DIV = 4
) (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // Host address and data devices
   input  wire logic        addr_dev_wr,
   input  wire logic        data_dev_wr,
   input  wire logic        word_mode,
   input  wire logic [15:0] host_wdata,
   output logic      [15:0] host_rdata,
   output logic             transfer_hold_request,
   output logic             read_direction_flag,
   output logic             write_direction_flag,
   // Video side
   input  wire logic        line_start,
   input  wire logic        repeated_line,
   input  wire logic        capture_en,
   input  wire logic [2:0]  camera_sel_in,
   output logic      [2:0]  camera_sel,
   input  wire logic [7:0]  adc_data,
   output logic      [7:0]  dac_data,
   output logic             sample_strobe,
   // Memory status
   output logic             cycle_lock_flag,
   output logic      [5:0]  chip_column_addr,
   output logic      [5:0]  chip_row_addr
);
   // ---------------------------------------------------------------
   // Storage and state
   // ---------------------------------------------------------------
   logic [7:0] store [65536];
   vfm_pkg::vfm_state_e state, next_state;
   logic [3:0]  tcnt, next_tcnt;
   logic        cyc_video, next_cyc_video;
   logic        hreq, next_hreq;
   logic        hrd, next_hrd;
   logic        hword, next_hword;
   logic [15:0] haddr, next_haddr;
   logic [15:0] hdata, next_hdata;
   logic [15:0] rdata, next_rdata;
   logic        rdflag, next_rdflag;
   logic [9:0]  hpos, next_hpos;
   logic [7:0]  vline, next_vline;
   logic [1:0]  sdiv, next_sdiv;
   logic [7:0]  vcol, next_vcol;
   logic [63:0] inbuf, next_inbuf;
   logic [63:0] outbuf, next_outbuf;
   logic [2:0]  bidx, next_bidx;
   logic        vreq, next_vreq;
   logic        vread, next_vread;
   logic [7:0]  vbase, next_vbase;
   logic [7:0]  vrow, next_vrow;
   logic [2:0]  cam, next_cam;
   logic        do_write;
   logic        fifo_ready, fifo_valid;
   logic [7:0]  fifo_data;
   vfm_pkg::vfm_chip_addr_s cad;

   // ---------------------------------------------------------------
   // Sample FIFO between the converter and the input buffer
   // ---------------------------------------------------------------
   vfm_fifo #(.WIDTH(8), .DEPTH(`VFM_FIFO_DEPTH)) u_fifo (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .in_valid  (sample_strobe && capture_en && !repeated_line),
      .in_ready  (fifo_ready),
      .in_data   (adc_data),
      .out_valid (fifo_valid),
      .out_ready (1'b1),
      .out_data  (fifo_data)
   );

   // ---------------------------------------------------------------
   // Address split
   // ---------------------------------------------------------------
   always_comb begin
      cad.card  = haddr[15:14];
      cad.block = haddr[13];
      cad.part  = haddr[0];
      cad.row   = haddr[12:7];
      cad.col   = {haddr[6:2], haddr[1]};
   end

   // ---------------------------------------------------------------
   // Video timing and host devices
   // ---------------------------------------------------------------
   always_comb begin
      next_hpos   = hpos;
      next_vline  = vline;
      next_sdiv   = 2'(sdiv + 1'b1);
      next_vcol   = vcol;
      next_inbuf  = inbuf;
      next_outbuf = outbuf;
      next_bidx   = bidx;
      next_vreq   = vreq;
      next_vread  = vread;
      next_vbase  = vbase;
      next_cam    = camera_sel_in == 3'h0 ? cam : camera_sel_in;
      next_hreq   = hreq;
      next_hrd    = hrd;
      next_hword  = hword;
      next_haddr  = haddr;
      next_hdata  = hdata;
      next_rdflag = rdflag;
      if (line_start || hpos == 10'(LINE_CLKS - 1)) begin
         next_hpos = '0;
         next_sdiv = '0;
         next_vcol = '0;
         next_bidx = '0;
         next_vline = line_start ? '0 : 8'(vline + 1'b1);
      end else begin
         next_hpos = 10'(hpos + 1'b1);
      end
      if (fifo_valid && vcol < 8'(`VFM_VID_COLS)
          && vline < 8'(`VFM_VID_LINES)) begin
         next_inbuf[bidx*8 +: 8] = fifo_data;
         next_vcol = 8'(vcol + 1'b1);
         next_bidx = 3'(bidx + 1'b1);
         if (bidx == 3'h7) begin
            next_vreq  = 1'b1;
            next_vread = 1'b0;
            next_vbase = {vcol[7:3], 3'h0};
         end
      end else if (sample_strobe && (!capture_en || repeated_line)
                   && vcol < 8'(`VFM_VID_COLS)) begin
         next_vcol = 8'(vcol + 1'b1);
         next_bidx = 3'(bidx + 1'b1);
         if (bidx == 3'h7) begin
            next_vreq  = 1'b1;
            next_vread = 1'b1;
            next_vbase = 8'(vcol + 1'b1);
         end
      end
      if (state == vfm_pkg::VFM_CAS && cyc_video) begin
         next_vreq = 1'b0;
         if (vread) begin
            for (int i = 0; i < 8; i++) begin
               next_outbuf[i*8 +: 8] = store[{vline, 8'(vbase + i)}];
            end
         end
      end
      if (data_dev_wr) begin
         next_hdata  = host_wdata;
         next_rdflag = 1'b0;
      end
      if (addr_dev_wr && !hreq) begin
         next_haddr  = word_mode ? {host_wdata[14:0], 1'b0} : host_wdata;
         next_hword  = word_mode;
         next_hreq   = 1'b1;
         next_hrd    = rdflag;
         next_rdflag = 1'b1;
      end
      if (state == vfm_pkg::VFM_CAS && !cyc_video) begin
         next_hreq   = 1'b0;
         next_rdflag = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Memory cycle sequencer
   // ---------------------------------------------------------------
   always_comb begin
      next_state     = state;
      next_tcnt      = tcnt;
      next_cyc_video = cyc_video;
      next_rdata     = rdata;
      do_write       = 1'b0;
      unique case (state)
         vfm_pkg::VFM_IDLE: begin
            if (vreq || hreq) begin
               next_cyc_video = vreq;
               next_state = vfm_pkg::VFM_RAS;
               next_tcnt  = '0;
            end
         end
         vfm_pkg::VFM_RAS: begin
            next_tcnt = 4'(tcnt + 1'b1);
            if (tcnt == 4'(`VFM_RAS_STEP)) begin
               next_state = vfm_pkg::VFM_CAS;
            end
         end
         vfm_pkg::VFM_CAS: begin
            next_tcnt  = 4'(tcnt + 1'b1);
            next_state = vfm_pkg::VFM_GAP;
            do_write   = cyc_video ? !vread : !hrd;
            if (!cyc_video && hrd) begin
               next_rdata = hword ? {store[haddr], store[haddr | 16'h0001]}
                                  : {8'h00, store[haddr]};
            end
         end
         vfm_pkg::VFM_GAP: begin
            next_tcnt = 4'(tcnt + 1'b1);
            if (tcnt >= 4'(`VFM_CYCLE_CLKS - `VFM_LOCK_CLR_CLKS - 1)) begin
               next_state = vfm_pkg::VFM_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (do_write) begin
         if (cyc_video) begin
            for (int i = 0; i < 8; i++) begin
               store[{vline, 8'(vbase + i)}] <= inbuf[i*8 +: 8];
            end
         end else if (hword) begin
            store[haddr]            <= hdata[15:8];
            store[haddr | 16'h0001] <= hdata[7:0];
         end else begin
            store[haddr] <= hdata[7:0];
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state <= vfm_pkg::VFM_IDLE;
         tcnt <= '0; cyc_video <= 1'b0; hreq <= 1'b0; hrd <= 1'b1;
         hword <= 1'b0; haddr <= '0; hdata <= '0; rdata <= '0;
         rdflag <= 1'b1; hpos <= '0; vline <= '0; sdiv <= '0;
         vcol <= '0; inbuf <= '0; outbuf <= '0; bidx <= '0;
         vreq <= 1'b0; vread <= 1'b0; vbase <= '0; cam <= '0;
         vrow <= '0; dac_data <= '0;
      end else begin
         state <= next_state;
         tcnt <= next_tcnt; cyc_video <= next_cyc_video;
         hreq <= next_hreq; hrd <= next_hrd; hword <= next_hword;
         haddr <= next_haddr; hdata <= next_hdata; rdata <= next_rdata;
         rdflag <= next_rdflag; hpos <= next_hpos; vline <= next_vline;
         sdiv <= next_sdiv; vcol <= next_vcol; inbuf <= next_inbuf;
         outbuf <= next_outbuf; bidx <= next_bidx; vreq <= next_vreq;
         vread <= next_vread; vbase <= next_vbase; cam <= next_cam;
         vrow <= next_vrow;
         dac_data <= outbuf[bidx*8 +: 8];
      end
   end

   always_comb begin
      next_vrow = vline[5:0] == 6'h00 ? 8'(vline) : vrow;
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign sample_strobe         = (sdiv == 2'(SAMPLE_DIV - 1));
   assign transfer_hold_request = hreq;
   assign read_direction_flag   = rdflag;
   assign write_direction_flag  = !rdflag;
   assign cycle_lock_flag       = (state != vfm_pkg::VFM_IDLE);
   assign host_rdata            = rdata;
   assign camera_sel            = cam;
   assign chip_row_addr         = cyc_video ? vline[5:0] : cad.row;
   assign chip_column_addr      = cyc_video ? vbase[7:2] : cad.col;
endmodule
`default_nettype wire

// File: logic/vfm_defs.svh
// Constants for the video frame memory controller
`ifndef VFM_DEFS_SVH
`define VFM_DEFS_SVH
`define VFM_CLK_PERIOD_NS   50
`define VFM_CYCLE_NS        700
`define VFM_CYCLE_CLKS      ((`VFM_CYCLE_NS + `VFM_CLK_PERIOD_NS - 1) / `VFM_CLK_PERIOD_NS)
`define VFM_RAS_GAP_NS      210
`define VFM_RAS_GAP_CLKS    ((`VFM_RAS_GAP_NS + `VFM_CLK_PERIOD_NS - 1) / `VFM_CLK_PERIOD_NS)
`define VFM_LOCK_CLR_NS     70
`define VFM_LOCK_CLR_CLKS   ((`VFM_LOCK_CLR_NS + `VFM_CLK_PERIOD_NS - 1) / `VFM_CLK_PERIOD_NS)
`define VFM_COL_STEP        2
`define VFM_RAS_STEP        1
`define VFM_VID_COLS        192
`define VFM_VID_LINES       240
`define VFM_FIFO_DEPTH      4
`endif

// File: logic/vfm_fifo.sv
// Small synchronous FIFO for video sample words
`timescale 1ns/1ps
`default_nettype none
module vfm_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wptr, rptr, next_wptr, next_rptr;
   logic [AW:0]      count, next_count;
   logic             push, pop;

   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rptr];

   always_comb begin
      next_wptr  = push ? AW'(wptr + 1'b1) : wptr;
      next_rptr  = pop ? AW'(rptr + 1'b1) : rptr;
      next_count = count;
      if (push && !pop) begin
         next_count = (AW+1)'(count + 1'b1);
      end else if (pop && !push) begin
         next_count = (AW+1)'(count - 1'b1);
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wptr  <= '0;
         rptr  <= '0;
         count <= '0;
      end else begin
         wptr  <= next_wptr;
         rptr  <= next_rptr;
         count <= next_count;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wptr] <= in_data;
      end
   end
endmodule
`default_nettype wire

// File: logic/vfm_pkg.sv
// Types for the video frame memory controller
package vfm_pkg;
   typedef enum logic [1:0] {VFM_IDLE, VFM_RAS, VFM_CAS, VFM_GAP} vfm_state_e;
   typedef struct packed {
      logic        wr;
      logic        word;
      logic [15:0] addr;
      logic [15:0] data;
   } vfm_host_req_s;
   typedef struct packed {
      logic [1:0] card;
      logic       block;
      logic       part;
      logic [5:0] row;
      logic [5:0] col;
   } vfm_chip_addr_s;
endpackage

// File: test/vfm_ctrl_bench.sv
// Self-checking bench for the frame store controller
`timescale 1ns/1ps
`default_nettype none
module vfm_ctrl_bench;
   logic        ref_clk, rst, addr_dev_wr, data_dev_wr, word_mode;
   logic        line_start, repeated_line, capture_en, sample_strobe;
   logic        transfer_hold_request, read_direction_flag;
   logic        write_direction_flag, cycle_lock_flag, ok;
   logic [15:0] host_wdata, host_rdata, d;
   logic [2:0]  camera_sel_in, camera_sel;
   logic [7:0]  adc_data, dac_data;
   logic [5:0]  chip_column_addr, chip_row_addr;
   int          n_fail = 0, checked = 0, cycles = 0;

   vfm_ctrl #(.LINE_CLKS(910), .SAMPLE_DIV(4)) u_vfm_ctrl (.ref_clk, .rst,
      .addr_dev_wr, .data_dev_wr, .word_mode, .host_wdata, .host_rdata,
      .transfer_hold_request, .read_direction_flag, .write_direction_flag,
      .line_start, .repeated_line, .capture_en, .camera_sel_in,
      .camera_sel, .adc_data, .dac_data, .sample_strobe, .cycle_lock_flag,
      .chip_column_addr, .chip_row_addr);
   vfm_host_model u_vfm_host_model (.ref_clk, .addr_dev_wr, .data_dev_wr,
      .word_mode, .host_wdata, .transfer_hold_request, .host_rdata);

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         summarize();
      end
   end
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] got,
                      input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      chk("read flag", {15'h0, read_direction_flag}, 16'h1);
      chk("write flag", {15'h0, write_direction_flag}, 16'h0);
      chk("hold", {15'h0, transfer_hold_request}, 16'h0);
   endtask
   task automatic t_bytes();
      u_vfm_host_model.strobe(1'b0, 1'b0, 16'h00a5);
      @(negedge ref_clk);
      chk("write flag", {15'h0, write_direction_flag}, 16'h1);
      u_vfm_host_model.strobe(1'b1, 1'b0, 16'hf7c4);
      u_vfm_host_model.settle(ok);
      chk("hold seen", {15'h0, ok}, 16'h1);
      chk("read flag", {15'h0, read_direction_flag}, 16'h1);
      u_vfm_host_model.write_access(1'b0, 16'hf7c5, 16'h003c, ok);
      u_vfm_host_model.read_access(1'b1, 16'h7be2, d, ok);
      chk("word read", d, 16'ha53c);
      u_vfm_host_model.write_access(1'b1, 16'h7be2, 16'h1e69, ok);
      u_vfm_host_model.read_access(1'b0, 16'hf7c4, d, ok);
      chk("left byte", {8'h00, d[7:0]}, 16'h001e);
      u_vfm_host_model.read_access(1'b0, 16'hf7c5, d, ok);
      chk("right byte", {8'h00, d[7:0]}, 16'h0069);
   endtask
   task automatic t_decode();
      for (int i = 0; i < 8; i++) begin
         u_vfm_host_model.write_access(1'b0, 16'(i) * 16'h2493,
            {8'h00, 8'(i * 17) ^ 8'hc3}, ok);
      end
      for (int i = 0; i < 8; i++) begin
         u_vfm_host_model.read_access(1'b0, 16'(i) * 16'h2493, d, ok);
         chk("decoded byte", {8'h00, d[7:0]}, {8'h00, 8'(i * 17) ^ 8'hc3});
      end
   endtask
   task automatic t_video();
      int n;
      for (int c = 0; c < 8; c++) begin
         camera_sel_in = 3'(c);
         repeat (2) @(negedge ref_clk);
         chk("camera", {13'h0, camera_sel}, 16'(c));
      end
      n = 0;
      repeat (40) begin
         @(negedge ref_clk);
         n += int'(sample_strobe);
      end
      chk("strobe count", 16'(n), 16'd10);
      line_start = 1'b1;
      capture_en = 1'b1;
      @(negedge ref_clk);
      line_start = 1'b0;
      for (int i = 0; i < 6; i++) begin
         repeated_line = i[0];
         u_vfm_host_model.write_access(1'b0, 16'hfdd9, 16'(i), ok);
         u_vfm_host_model.read_access(1'b0, 16'hfdd9, d, ok);
         chk("free area byte", {8'h00, d[7:0]}, 16'(i));
         chk("access under video", {15'h0, ok}, 16'h1);
      end
   endtask
   // Samples pass the design's own FIFO and input buffer into row 0
   task automatic t_fifo();
      repeated_line = 1'b0;
      capture_en    = 1'b1;
      adc_data      = 8'h3c;
      line_start    = 1'b1;
      @(negedge ref_clk);
      line_start    = 1'b0;
      repeat (80) @(negedge ref_clk);
      for (int i = 0; i < 8; i++) begin
         u_vfm_host_model.read_access(1'b0, 16'(i), d, ok);
         chk("captured byte", {8'h00, d[7:0]}, 16'h003c);
      end
      chk("capture hold", {15'h0, ok}, 16'h1);
      chk("capture read flag", {15'h0, read_direction_flag}, 16'h1);
   endtask
   initial begin
      rst = 1'b1;
      line_start = 1'b0;
      repeated_line = 1'b0;
      capture_en = 1'b0;
      camera_sel_in = 3'h0;
      adc_data = 8'h5a;
      repeat (8) @(negedge ref_clk);
      t_reset();
      rst = 1'b0;
      @(negedge ref_clk);
      t_bytes();
      t_decode();
      t_video();
      t_fifo();
      summarize();
   end
endmodule
`default_nettype wire

// File: test/vfm_ctrl_props.sv
// Port checker for the frame store controller
`timescale 1ns/1ps
`default_nettype none
module vfm_ctrl_props #(
   parameter int LINE_CLKS  = 910,
   parameter int SAMPLE_DIV = 4
) (
   // Clock and reset
   input wire logic       ref_clk,
   input wire logic       rst,
   // Host side
   input wire logic       addr_dev_wr,
   input wire logic       data_dev_wr,
   input wire logic       transfer_hold_request,
   input wire logic       read_direction_flag,
   input wire logic       write_direction_flag,
   // Video side and memory status
   input wire logic       line_start,
   input wire logic [2:0] camera_sel_in,
   input wire logic [2:0] camera_sel,
   input wire logic       sample_strobe,
   input wire logic       cycle_lock_flag
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   hold_rise_a: assert property (
      addr_dev_wr && !transfer_hold_request |=> transfer_hold_request)
      else $error("hold request not raised after address write");
   hold_span_a: assert property (
      $rose(transfer_hold_request) |-> transfer_hold_request [*3])
      else $error("hold request dropped before memory access");
   hold_end_a: assert property (
      $rose(transfer_hold_request) |-> ##[1:40] !transfer_hold_request)
      else $error("host access not completed in time");
   data_clear_a: assert property (
      data_dev_wr && !transfer_hold_request
      |=> write_direction_flag && !read_direction_flag)
      else $error("data write did not select write direction");
   end_read_a: assert property (
      $fell(transfer_hold_request)
      |-> ##[0:1] (read_direction_flag && !write_direction_flag))
      else $error("access did not end in read direction");
   strobe_gap_a: assert property (@(posedge ref_clk)
      disable iff (rst || line_start)
      sample_strobe |=> (!sample_strobe) [*3] ##1 sample_strobe)
      else $error("sample strobe not every four clocks");
   lock_len_a: assert property (
      $rose(cycle_lock_flag) |-> ##[1:14] !cycle_lock_flag)
      else $error("memory cycle longer than allowed");
   lock_start_a: assert property (
      addr_dev_wr && !transfer_hold_request |-> ##[1:16] cycle_lock_flag)
      else $error("no memory cycle after host request");
   camera_sel_a: assert property (
      $changed(camera_sel_in) |=> camera_sel == $past(camera_sel_in))
      else $error("camera selection not taken");
endmodule
bind vfm_ctrl vfm_ctrl_props #(.LINE_CLKS(LINE_CLKS),
   .SAMPLE_DIV(SAMPLE_DIV)) u_vfm_ctrl_props (.ref_clk, .rst,
   .addr_dev_wr, .data_dev_wr, .transfer_hold_request,
   .read_direction_flag, .write_direction_flag, .line_start,
   .camera_sel_in, .camera_sel, .sample_strobe, .cycle_lock_flag);
`default_nettype wire

// File: test/vfm_host_model.sv
// Host processor model for the address and data devices
`timescale 1ns/1ps
`default_nettype none
module vfm_host_model (
   // Clock
   input  wire logic        ref_clk,
   // Host I/O toward the controller
   output var logic         addr_dev_wr,
   output var logic         data_dev_wr,
   output var logic         word_mode,
   output var logic  [15:0] host_wdata,
   input  wire logic        transfer_hold_request,
   input  wire logic [15:0] host_rdata
);
   initial begin
      addr_dev_wr = 1'b0;
      data_dev_wr = 1'b0;
      word_mode   = 1'b0;
      host_wdata  = 16'h0000;
   end
   // One write to a device; afterwards the bus no longer holds the value
   task automatic strobe(input logic to_addr, input logic wrd,
                         input logic [15:0] val);
      @(negedge ref_clk);
      addr_dev_wr = to_addr;
      data_dev_wr = !to_addr;
      word_mode   = wrd;
      host_wdata  = val;
      @(negedge ref_clk);
      addr_dev_wr = 1'b0;
      data_dev_wr = 1'b0;
      host_wdata  = ~val;
   endtask
   // No further I/O while the hold request stands
   task automatic settle(output logic ok);
      int n;
      n = 0;
      while (transfer_hold_request === 1'b1 && n < 60) begin
         @(negedge ref_clk);
         n++;
      end
      ok = (n > 0 && n < 60);
   endtask
   task automatic write_access(input logic wrd, input logic [15:0] a,
                               input logic [15:0] d, output logic ok);
      strobe(1'b0, wrd, d);
      strobe(1'b1, wrd, a);
      settle(ok);
   endtask
   task automatic read_access(input logic wrd, input logic [15:0] a,
                              output logic [15:0] d, output logic ok);
      strobe(1'b1, wrd, a);
      settle(ok);
      d = host_rdata;
   endtask
endmodule
`default_nettype wire
